/* rtl/ssr_defines.vh */
`ifndef SSR_DEFINES_VH
`define SSR_DEFINES_VH
// register byte offsets on the apb bus
`define SSR_OFF_BAUD_CONTROL 12'h000
`define SSR_OFF_RECEIVE_DATA 12'h004
`define SSR_OFF_RECEIVE_CONTROL_STATUS 12'h008
`define SSR_OFF_BAUD_DIVISOR_LOW 12'h00c
`define SSR_OFF_BAUD_DIVISOR_HIGH 12'h010
`define SSR_OFF_TRANSMIT_CONTROL_STATUS 12'h014
// receive_control_status fields
`define SSR_RCS_PORT_ENABLE 7
`define SSR_RCS_NINE_BIT 6
`define SSR_RCS_SINGLE_EN 5
`define SSR_RCS_CONT_EN 4
`define SSR_RCS_OVERRUN 1
`define SSR_RCS_NINTH 0
// transmit_control_status fields
`define SSR_TCS_CLK_MASTER 7
`define SSR_TCS_SYNC 4
`define SSR_TCS_BAUD_HIGH 2
// baud_control fields
`define SSR_BC_DATA_INVERT 5
`define SSR_BC_CLK_IDLE_HIGH 4
`define SSR_BC_BAUD_16 3
// reset values and fifo depth
`define SSR_RST_BYTE 8'h00
`define SSR_FIFO_DEPTH 2'h2
`endif

/* rtl/ssr_receiver.v */
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defines.vh"

// Operation
// - reception starts only once single or continuous receive enable is set
// - single enable alone: master clocks one character, then clears single enable
// - continuous enable keeps master clocks running until it is cleared
// - clearing continuous enable mid-character stops clock, drops partial character
// - both enables set: master clears single after first character, continuous goes on
// - data pin sampled on trailing clock edge into the shift register
// - full character sets receive flag and enters two-deep fifo
// - receive data shows low eight bits of oldest character; read consumes it
// - receive flag stays high while fifo holds any unread character
// - slave takes clock from the line, one bit per far-end clock
// - third character with full fifo sets overrun, fifo untouched
// - during overrun buffered characters readable, no new characters taken
// - overrun from single mode clears on receive data read
// - overrun from continuous mode clears by clearing continuous or port enable
// - nine-bit mode shifts nine bits; ninth bit field shows oldest msb
// - slave when synchronous, clock source slave and port enabled
// - port enable activates port; clearing it resets receive logic
// - master drives one clock cycle per data bit, no extras
// - clock idle high samples on rising edges, idle low on falling
// - data invert set makes received data active low
module ssr_receiver (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // shift clock line
   input wire shift_clock_line_in,
   output reg shift_clock_line_out,
   output reg shift_clock_line_oe_n,
   // data line, receive only
   input wire data_line_in,
   output wire data_line_out,
   output wire data_line_oe_n,
   // status
   output wire rx_flag
);
   localparam ST_IDLE = 2'h0;
   localparam ST_LEAD = 2'h1;
   localparam ST_TRAIL = 2'h2;

   reg [7:0] baud_ctl_r;
   reg [7:0] div_lo_r;
   reg [7:0] div_hi_r;
   reg [7:0] tx_ctl_r;
   reg port_enable_r;
   reg nine_bit_rx_select_r;
   reg single_rx_enable_r;
   reg continuous_rx_enable_r;
   reg overrun_flag_r;
   reg ovr_from_cont_r;
   reg [8:0] fifo_r [0:1];
   reg rd_ptr_r;
   reg [1:0] count_r;
   reg [8:0] rx_shift_reg_r;
   reg [3:0] bit_cnt_r;
   reg [1:0] state_r;
   reg [15:0] baud_cnt_r;
   reg ck_s1_r, ck_s2_r, ck_s3_r;
   reg dt_s1_r, dt_s2_r;

   wire wr_acc = psel & penable & pwrite;
   wire rd_acc = psel & penable & ~pwrite;
   wire mapped = (paddr == `SSR_OFF_BAUD_CONTROL) |
                 (paddr == `SSR_OFF_RECEIVE_DATA) |
                 (paddr == `SSR_OFF_RECEIVE_CONTROL_STATUS) |
                 (paddr == `SSR_OFF_BAUD_DIVISOR_LOW) |
                 (paddr == `SSR_OFF_BAUD_DIVISOR_HIGH) |
                 (paddr == `SSR_OFF_TRANSMIT_CONTROL_STATUS);
   wire wr_rcs = wr_acc & (paddr == `SSR_OFF_RECEIVE_CONTROL_STATUS);
   wire rd_data = rd_acc & (paddr == `SSR_OFF_RECEIVE_DATA);
   wire pop = rd_data & (count_r != 2'h0);

   wire sync_mode = tx_ctl_r[`SSR_TCS_SYNC];
   wire master = tx_ctl_r[`SSR_TCS_CLK_MASTER];
   wire idle_high = baud_ctl_r[`SSR_BC_CLK_IDLE_HIGH];
   wire invert = baud_ctl_r[`SSR_BC_DATA_INVERT];
   wire any_en = single_rx_enable_r | continuous_rx_enable_r;
   // receive only when synchronous, enabled, and not blocked by overrun
   wire active = port_enable_r & sync_mode & any_en & ~overrun_flag_r;
   wire slave_rx = active & ~master;
   wire [3:0] char_bits = nine_bit_rx_select_r ? 4'h9 : 4'h8;
   wire [15:0] divisor = {div_hi_r, div_lo_r};

   // external clock edges, level normalised so trailing edge is a fall of ck_now
   wire ck_prev = ck_s3_r ^ idle_high;
   wire ck_now = ck_s2_r ^ idle_high;
   wire ext_trail = ck_prev & ~ck_now;
   wire dt_bit = dt_s2_r ^ invert;
   wire baud_tick = (baud_cnt_r == 16'h0000);
   wire mst_trail = active & master & (state_r == ST_TRAIL) & baud_tick;
   wire sample = mst_trail | (slave_rx & ext_trail);
   wire last_bit = sample & (bit_cnt_r == char_bits - 4'h1);
   wire [8:0] shifted = nine_bit_rx_select_r ? {dt_bit, rx_shift_reg_r[8:1]}
                                              : {1'b0, dt_bit, rx_shift_reg_r[7:1]};
   wire full = (count_r == `SSR_FIFO_DEPTH);
   wire push = last_bit & ~full;
   wire [8:0] head = fifo_r[rd_ptr_r];

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign data_line_out = 1'b0;
   assign data_line_oe_n = 1'b1;
   assign rx_flag = (count_r != 2'h0);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ck_s1_r <= 1'b0;
         ck_s2_r <= 1'b0;
         ck_s3_r <= 1'b0;
         dt_s1_r <= 1'b0;
         dt_s2_r <= 1'b0;
      end else begin
         ck_s1_r <= shift_clock_line_in;
         ck_s2_r <= ck_s1_r;
         ck_s3_r <= ck_s2_r;
         dt_s1_r <= data_line_in;
         dt_s2_r <= dt_s1_r;
      end
   end

   // configuration registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_ctl_r <= `SSR_RST_BYTE;
         div_lo_r <= `SSR_RST_BYTE;
         div_hi_r <= `SSR_RST_BYTE;
         tx_ctl_r <= `SSR_RST_BYTE;
         port_enable_r <= 1'b0;
         nine_bit_rx_select_r <= 1'b0;
      end else if (wr_acc) begin
         case (paddr)
            `SSR_OFF_BAUD_CONTROL: baud_ctl_r <= pwdata[7:0] & 8'h38;
            `SSR_OFF_BAUD_DIVISOR_LOW: div_lo_r <= pwdata[7:0];
            `SSR_OFF_BAUD_DIVISOR_HIGH: div_hi_r <= pwdata[7:0];
            `SSR_OFF_TRANSMIT_CONTROL_STATUS: tx_ctl_r <= pwdata[7:0] & 8'h94;
            `SSR_OFF_RECEIVE_CONTROL_STATUS: begin
               port_enable_r <= pwdata[`SSR_RCS_PORT_ENABLE];
               nine_bit_rx_select_r <= pwdata[`SSR_RCS_NINE_BIT];
            end
            default: ;
         endcase
      end
   end

   // receive enables and overrun
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         single_rx_enable_r <= 1'b0;
         continuous_rx_enable_r <= 1'b0;
         overrun_flag_r <= 1'b0;
         ovr_from_cont_r <= 1'b0;
      end else if (!port_enable_r) begin
         // disabled port holds receive logic in reset; enables stay writable
         overrun_flag_r <= 1'b0;
         ovr_from_cont_r <= 1'b0;
         if (wr_rcs) begin
            single_rx_enable_r <= pwdata[`SSR_RCS_SINGLE_EN];
            continuous_rx_enable_r <= pwdata[`SSR_RCS_CONT_EN];
         end
      end else begin
         if (wr_rcs) begin
            single_rx_enable_r <= pwdata[`SSR_RCS_SINGLE_EN];
            continuous_rx_enable_r <= pwdata[`SSR_RCS_CONT_EN];
         end
         // single enable self-clears after a master character; wins over write
         if (last_bit & master)
            single_rx_enable_r <= 1'b0;
         if (last_bit & full) begin
            overrun_flag_r <= 1'b1;
            ovr_from_cont_r <= continuous_rx_enable_r;
         end else if (overrun_flag_r) begin
            if (ovr_from_cont_r & ~continuous_rx_enable_r)
               overrun_flag_r <= 1'b0;
            else if (~ovr_from_cont_r & rd_data)
               overrun_flag_r <= 1'b0;
         end
      end
   end

   // fifo, two characters
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_r[0] <= 9'h000;
         fifo_r[1] <= 9'h000;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end else if (!port_enable_r) begin
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (push)
            fifo_r[rd_ptr_r ^ count_r[0]] <= shifted;
         if (pop)
            rd_ptr_r <= ~rd_ptr_r;
         count_r <= count_r + {1'b0, push} - {1'b0, pop};
      end
   end

   // shift engine and master clock generator
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 4'h0;
         rx_shift_reg_r <= 9'h000;
         baud_cnt_r <= 16'h0000;
         shift_clock_line_out <= 1'b0;
         shift_clock_line_oe_n <= 1'b1;
      end else begin
         shift_clock_line_oe_n <= ~(port_enable_r & sync_mode & master);
         if (!active) begin
            // enable dropped mid-character: clock stops, partial discarded
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            baud_cnt_r <= divisor;
            shift_clock_line_out <= idle_high;
         end else begin
            if (sample) begin
               rx_shift_reg_r <= shifted;
               bit_cnt_r <= last_bit ? 4'h0 : bit_cnt_r + 4'h1;
            end
            if (master) begin
               if (baud_tick)
                  baud_cnt_r <= divisor;
               else
                  baud_cnt_r <= baud_cnt_r - 16'h0001;
               case (state_r)
                  ST_IDLE: begin
                     state_r <= ST_LEAD;
                     baud_cnt_r <= divisor;
                  end
                  ST_LEAD: if (baud_tick) begin
                     state_r <= ST_TRAIL;
                     shift_clock_line_out <= ~idle_high;
                  end
                  ST_TRAIL: if (baud_tick) begin
                     shift_clock_line_out <= idle_high;
                     // continuous keeps going; single alone stops after one char
                     state_r <= (last_bit & ~continuous_rx_enable_r) ? ST_IDLE
                                                                    : ST_LEAD;
                  end
                  default: state_r <= ST_IDLE;
               endcase
            end
         end
      end
   end

   // read mux
   always @* begin
      prdata = 32'h0000_0000;
      case (paddr)
         `SSR_OFF_BAUD_CONTROL: prdata[7:0] = baud_ctl_r;
         `SSR_OFF_RECEIVE_DATA: prdata[7:0] = head[7:0];
         `SSR_OFF_RECEIVE_CONTROL_STATUS: begin
            prdata[`SSR_RCS_PORT_ENABLE] = port_enable_r;
            prdata[`SSR_RCS_NINE_BIT] = nine_bit_rx_select_r;
            prdata[`SSR_RCS_SINGLE_EN] = single_rx_enable_r;
            prdata[`SSR_RCS_CONT_EN] = continuous_rx_enable_r;
            prdata[`SSR_RCS_OVERRUN] = overrun_flag_r;
            prdata[`SSR_RCS_NINTH] = head[8];
         end
         `SSR_OFF_BAUD_DIVISOR_LOW: prdata[7:0] = div_lo_r;
         `SSR_OFF_BAUD_DIVISOR_HIGH: prdata[7:0] = div_hi_r;
         `SSR_OFF_TRANSMIT_CONTROL_STATUS: prdata[7:0] = tx_ctl_r;
         default: prdata = 32'h0000_0000;
      endcase
   end
endmodule
`default_nettype wire

/* verif/ssr_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defines.vh"
module ssr_checker (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // lines
   input wire logic shift_clock_line_out,
   input wire logic shift_clock_line_oe_n,
   input wire logic data_line_oe_n,
   input wire logic rx_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [4:0] cnt_r;
   logic ck_r, tm_r, pe_r;
   wire wacc = psel && penable && pready && pwrite;
   wire rdd = psel && penable && !pwrite && paddr == `SSR_OFF_RECEIVE_DATA;
   wire mst = tm_r && pe_r;
   // cycles since the clock line last moved, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 5'h1f;
         ck_r <= 1'b0;
         tm_r <= 1'b0;
         pe_r <= 1'b0;
      end else begin
         ck_r <= shift_clock_line_out;
         cnt_r <= (shift_clock_line_out != ck_r) ? 5'h0 : cnt_r + {4'h0, cnt_r != 5'h1f};
         if (wacc && paddr == `SSR_OFF_TRANSMIT_CONTROL_STATUS) tm_r <= pwdata[7] && pwdata[4];
         if (wacc && paddr == `SSR_OFF_RECEIVE_CONTROL_STATUS) pe_r <= pwdata[7];
      end
   end
   sequence s_acc; psel && penable; endsequence
   property p_ready; s_acc |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("wait state seen");
   property p_err; s_acc ##0 paddr > 12'h014 |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
   property p_hi; s_acc ##0 !pwrite |-> prdata[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_oe; mst == $past(mst) |-> shift_clock_line_oe_n == !mst; endproperty
   a_oe: assert property (p_oe) else $error("clock drive wrong for mode");
   property p_dat; !shift_clock_line_oe_n |-> data_line_oe_n; endproperty
   a_dat: assert property (p_dat) else $error("data pin driven");
   // writes may move the clock early, e.g. continuous enable cleared mid-character
   property p_half;
      $changed(shift_clock_line_out) && !$past(wacc) && !$past(wacc, 2) && !$past(wacc, 3)
         |-> cnt_r >= 5'h7;
   endproperty
   a_half: assert property (p_half) else $error("clock half period short");
   property p_fall; $fell(rx_flag) |-> $past(rdd) || $past(wacc) || $past(wacc, 2); endproperty
   a_fall: assert property (p_fall) else $error("flag dropped with no read");
   // push lands on the trailing edge, so the flag rises as the line settles to idle
   property p_rise;
      $rose(rx_flag) && !shift_clock_line_oe_n |-> $changed(shift_clock_line_out);
   endproperty
   a_rise: assert property (p_rise) else $error("flag not tied to clock edge");
endmodule
bind ssr_receiver ssr_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .shift_clock_line_out, .shift_clock_line_oe_n,
   .data_line_oe_n, .rx_flag);
`default_nettype wire

/* verif/ssr_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module ssr_peer (
   // line side
   input wire logic ck_line,
   input wire logic idle_high,
   input wire logic [8:0] word,
   input wire logic [3:0] nbits,
   // outputs
   output logic ck_drv,
   output logic dat
);
   int idx = 0;
   initial ck_drv = 1'b0;
   initial dat = 1'b0;
   task automatic restart();
      idx = 0;
   endtask
   // slave clock only runs inside a frame
   task automatic burst(input int n);
      #3;
      repeat (n) begin
         #80 ck_drv = ~idle_high;
         #80 ck_drv = idle_high;
      end
   endtask
   always @(ck_line) begin
      if (ck_line !== idle_high) begin
         dat = word[idx];
         idx = idx + 1;
      end else if (idx == nbits) begin
         idx = 0;
         #60 dat = ~dat;
      end
   end
endmodule
`default_nettype wire

/* verif/sync_serial_receiver_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defines.vh"
module sync_serial_receiver_test;
   localparam logic [11:0] RD = `SSR_OFF_RECEIVE_DATA;
   localparam logic [11:0] RCS = `SSR_OFF_RECEIVE_CONTROL_STATUS;
   localparam logic [11:0] BC = `SSR_OFF_BAUD_CONTROL;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ih = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [8:0] word = 9'h0, w;
   logic [3:0] nbits = 4'h8;
   logic [32:0] exp_q[$];
   int fail_count = 0, num_checks = 0, edges = 0, seed = 32'h647e4663;
   wire [31:0] prdata;
   wire pready, pslverr, ck_out, ck_oe_n, ck_drv, dat, rx_flag;
   wire ck_line = ck_oe_n ? ck_drv : ck_out;
   ssr_receiver i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .shift_clock_line_in(ck_line), .shift_clock_line_out(ck_out),
      .shift_clock_line_oe_n(ck_oe_n), .data_line_in(dat), .data_line_out(),
      .data_line_oe_n(), .rx_flag);
   ssr_peer u_peer (.ck_line, .idle_high(ih), .word, .nbits, .ck_drv, .dat);
   always #5 pclk = ~pclk;
   always @(ck_out) if (ck_out !== ih) edges++;
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) fail_count++;
      if (n >= 20) report_and_stop();
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [8:0] e);
      exp_q.push_back({e[8], 24'h0, e[7:0]});
      apb(1'b0, a, 8'h0);
   endtask
   task automatic wait_flag(input int lim);
      int n;
      n = 0;
      while (rx_flag !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
      if (n >= lim) fail_count++;
      if (n >= lim) report_and_stop();
   endtask
   // read results are judged where they appear
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0)
         chk({pslverr, prdata}, exp_q.pop_front());
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(BC, 9'h0);
      rd(RCS, 9'h0);
      rd(12'h018, 9'h100);
      apb(1'b1, `SSR_OFF_BAUD_DIVISOR_LOW, 8'h07);
      apb(1'b1, `SSR_OFF_TRANSMIT_CONTROL_STATUS, 8'h90);
      apb(1'b1, RCS, 8'h80);
      w = 9'($random(seed));
      word <= w;
      repeat (3) begin
         apb(1'b1, RCS, 8'ha0);
         repeat (148) @(posedge pclk);
      end
      chk(33'(edges), 33'h18);
      rd(RCS, 9'h82);
      rd(RD, {1'b0, w[7:0]});
      rd(RCS, 9'h80);
      rd(RD, {1'b0, w[7:0]});
      @(negedge pclk);
      chk(33'(rx_flag), 33'h0);
      w = 9'($random(seed));
      word <= w;
      u_peer.restart();
      apb(1'b1, RCS, 8'hb0);
      wait_flag(400);
      rd(RCS, 9'h90);
      rd(RD, {1'b0, w[7:0]});
      repeat (424) @(posedge pclk);
      rd(RCS, 9'h92);
      rd(RD, {1'b0, w[7:0]});
      rd(RD, {1'b0, w[7:0]});
      repeat (200) @(posedge pclk);
      rd(RCS, 9'h92);
      apb(1'b1, RCS, 8'h80);
      rd(RCS, 9'h80);
      u_peer.restart();
      apb(1'b1, RCS, 8'h90);
      repeat (60) @(posedge pclk);
      apb(1'b1, RCS, 8'h80);
      repeat (200) @(posedge pclk);
      chk(33'(ck_out), 33'h0);
      chk(33'(rx_flag), 33'h0);
      ih <= 1'b1;
      apb(1'b1, BC, 8'h30);
      w = 9'($random(seed));
      word <= ~w;
      nbits <= 4'h9;
      u_peer.restart();
      edges = 0;
      apb(1'b1, RCS, 8'he0);
      wait_flag(400);
      rd(RCS, {1'b0, 7'h60, w[8]});
      rd(RD, {1'b0, w[7:0]});
      chk(33'(edges), 33'h9);
      apb(1'b1, RCS, 8'he0);
      wait_flag(400);
      apb(1'b1, RCS, 8'h00);
      rd(RCS, 9'h0);
      chk(33'(rx_flag), 33'h0);
      apb(1'b1, BC, 8'h00);
      ih <= 1'b0;
      apb(1'b1, `SSR_OFF_TRANSMIT_CONTROL_STATUS, 8'h10);
      w = 9'($random(seed));
      word <= w;
      nbits <= 4'h8;
      u_peer.restart();
      apb(1'b1, RCS, 8'h90);
      u_peer.burst(8);
      wait_flag(50);
      rd(RD, {1'b0, w[7:0]});
      chk(33'(ck_oe_n), 33'h1);
      report_and_stop();
   end
endmodule
`default_nettype wire
